// ---- rtl/usb_host_transaction_regs.sv ----
// host transaction set-up and result registers for the serial link engines
`include "usb_host_txn_cfg.svh"

module usb_host_transaction_regs #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // register bus
  input  wire logic [15:0]                   regAddr,
  input  wire logic                          regWrEn,
  input  wire logic [15:0]                   regWrData,
  input  wire logic                          regRdEn,
  output logic [15:0]                        regRdData,
  output logic                               regRdValid,
  // serial link engine, per port
  input  wire usb_host_txn_pkg::txn_result_t portResult [NUM_PORTS],
  input  wire logic [9:0]                    hostCount  [NUM_PORTS],
  output usb_host_txn_pkg::port_cmd_t        portCmd    [NUM_PORTS]
);

  // ==========================================
  // address decode
  function automatic logic [15:0] token_offset(input int port);
    return (port == 0) ? `HOST1_TOKEN_SELECT_OFS : `HOST2_TOKEN_SELECT_OFS;
  endfunction

  function automatic logic [15:0] diff_offset(input int port);
    return (port == 0) ? `HOST1_COUNT_DIFF_OFS : `HOST2_COUNT_DIFF_OFS;
  endfunction

  function automatic logic hits(input logic [15:0] addr, input logic [15:0] ofs);
    return addr == ofs;
  endfunction

  // ==========================================
  // token classification
  function automatic logic is_legal_token(input logic [3:0] code);
    logic legal;
    legal = 1'b0;
    unique case (code)
      `TOK_SETUP, `TOK_IN, `TOK_OUT, `TOK_SOF, `TOK_PREAMBLE: legal = 1'b1;
      `TOK_NAK, `TOK_STALL, `TOK_DATA0, `TOK_DATA1:           legal = 1'b1;
      default:                                                legal = 1'b0;
    endcase
    return legal;
  endfunction

  function automatic logic is_handshake(input logic [3:0] code);
    return (code == `TOK_NAK) || (code == `TOK_STALL);
  endfunction

  // ==========================================
  // per-port registers
  usb_host_txn_pkg::ep_status_t portStatus [NUM_PORTS];
  logic [15:0]                  portDiff   [NUM_PORTS];
  logic [NUM_PORTS-1:0]         tokenHit;
  logic [NUM_PORTS-1:0]         diffHit;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
    usb_host_txn_pkg::token_sel_t tokenFf;
    usb_host_txn_pkg::token_sel_t nxtTokenFf;
    logic [6:0]                   addrFf;
    logic [6:0]                   nxtAddrFf;
    logic                         loadFf;
    logic                         nxtLoadFf;
    logic                         legalFf;
    logic                         nxtLegalFf;

    assign tokenHit[p] = hits(regAddr, token_offset(p));
    assign diffHit[p]  = hits(regAddr, diff_offset(p));

    always_comb begin
      nxtTokenFf = tokenFf;
      nxtAddrFf  = addrFf;
      nxtLegalFf = legalFf;
      nxtLoadFf  = 1'b0;
      // reserved bits of both write words are dropped
      if (regWrEn && tokenHit[p]) begin
        nxtTokenFf.code     = regWrData[`TOKEN_CODE_MSB:`TOKEN_CODE_LSB];
        nxtTokenFf.endpoint = regWrData[`TOKEN_EP_MSB:`TOKEN_EP_LSB];
        nxtLegalFf          = is_legal_token(regWrData[`TOKEN_CODE_MSB:`TOKEN_CODE_LSB]);
        nxtLoadFf           = 1'b1;
      end
      if (regWrEn && diffHit[p]) begin
        nxtAddrFf = regWrData[`TARGET_ADDR_MSB:`TARGET_ADDR_LSB];
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        tokenFf <= `TOKEN_SELECT_RST;
        addrFf  <= `TARGET_ADDR_RST;
        loadFf  <= 1'b0;
        legalFf <= 1'b0;
      end else begin
        tokenFf <= nxtTokenFf;
        addrFf  <= nxtAddrFf;
        loadFf  <= nxtLoadFf;
        legalFf <= nxtLegalFf;
      end
    end

    // engine sees registered set-up values only
    always_comb begin
      portCmd[p].token      = tokenFf;
      portCmd[p].targetAddr = addrFf;
      portCmd[p].tokenLoad  = loadFf;
      portCmd[p].tokenLegal = legalFf;
      portCmd[p].preamble   = tokenFf.code == `TOK_PREAMBLE;
      portCmd[p].handshake  = is_handshake(tokenFf.code);
    end

    txn_result_capture uCapture (
      .clk       (clk),
      .rst_n     (rst_n),
      .result    (portResult[p]),
      .hostCount (hostCount[p]),
      .status    (portStatus[p]),
      .countDiff (portDiff[p])
    );
  end

  // ==========================================
  // status word layout
  function automatic logic [15:0] status_word(input usb_host_txn_pkg::ep_status_t st);
    logic [15:0] w;
    w                      = `READ_IDLE_VALUE;
    w[`STAT_ACK_BIT]       = st.ack;
    w[`STAT_ERROR_BIT]     = st.error;
    w[`STAT_TIMEOUT_BIT]   = st.timeout;
    w[`STAT_SEQ_BIT]       = st.seq;
    w[`STAT_LENEXC_BIT]    = st.lenExc;
    w[`STAT_NAK_BIT]       = st.nak;
    w[`STAT_STALL_BIT]     = st.stall;
    w[`STAT_UNDERFLOW_BIT] = st.underflow;
    w[`STAT_OVERFLOW_BIT]  = st.overflow;
    return w;
  endfunction

  // ==========================================
  // read path
  logic [15:0] rdDataFf;
  logic [15:0] nxtRdDataFf;
  logic        rdValidFf;
  logic        nxtRdValidFf;

  always_comb begin
    nxtRdDataFf  = `READ_IDLE_VALUE;
    nxtRdValidFf = regRdEn;
    if (regRdEn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (tokenHit[p]) begin
          nxtRdDataFf = status_word(portStatus[p]);
        end
        if (diffHit[p]) begin
          nxtRdDataFf = portDiff[p];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdDataFf  <= `READ_IDLE_VALUE;
      rdValidFf <= 1'b0;
    end else begin
      rdDataFf  <= nxtRdDataFf;
      rdValidFf <= nxtRdValidFf;
    end
  end

  assign regRdData  = rdDataFf;
  assign regRdValid = rdValidFf;

endmodule

// ---- shared/usb_host_txn_cfg.svh ----
// offsets, field positions, codes and reset values of the host transaction registers
`ifndef USB_HOST_TXN_CFG_SVH
`define USB_HOST_TXN_CFG_SVH

// ==========================================
// register offsets (16-bit register bus)
`define HOST1_TOKEN_SELECT_OFS   16'hC086
`define HOST1_COUNT_DIFF_OFS     16'hC088
`define HOST2_TOKEN_SELECT_OFS   16'hC0A6
`define HOST2_COUNT_DIFF_OFS     16'hC0A8

// ==========================================
// field positions
`define TOKEN_CODE_MSB           7
`define TOKEN_CODE_LSB           4
`define TOKEN_EP_MSB             3
`define TOKEN_EP_LSB             0
`define TARGET_ADDR_MSB          6
`define TARGET_ADDR_LSB          0
`define STAT_ACK_BIT             0
`define STAT_ERROR_BIT           1
`define STAT_TIMEOUT_BIT         2
`define STAT_SEQ_BIT             3
`define STAT_LENEXC_BIT          5
`define STAT_NAK_BIT             6
`define STAT_STALL_BIT           7
`define STAT_UNDERFLOW_BIT       10
`define STAT_OVERFLOW_BIT        11
`define DIFF_OVF_MSB             15
`define DIFF_OVF_LSB             10
`define DIFF_OVF_FILL            6'h3F

// ==========================================
// token codes
`define TOK_SETUP                4'hD
`define TOK_IN                   4'h9
`define TOK_OUT                  4'h1
`define TOK_SOF                  4'h5
`define TOK_PREAMBLE             4'hC
`define TOK_NAK                  4'hA
`define TOK_STALL                4'hE
`define TOK_DATA0                4'h3
`define TOK_DATA1                4'hB

// ==========================================
// reset values
`define TOKEN_SELECT_RST         8'h00
`define TARGET_ADDR_RST          7'h00
`define COUNT_DIFF_RST           16'h0000
`define READ_IDLE_VALUE          16'h0000

`endif

// ---- shared/usb_host_txn_pkg.sv ----
// types shared by the host transaction register logic
`include "usb_host_txn_cfg.svh"

package usb_host_txn_pkg;

  // ==========================================
  // token codes
  typedef enum logic [3:0] {
    TOKEN_SETUP    = `TOK_SETUP,
    TOKEN_IN       = `TOK_IN,
    TOKEN_OUT      = `TOK_OUT,
    TOKEN_SOF      = `TOK_SOF,
    TOKEN_PREAMBLE = `TOK_PREAMBLE,
    TOKEN_NAK      = `TOK_NAK,
    TOKEN_STALL    = `TOK_STALL,
    TOKEN_DATA0    = `TOK_DATA0,
    TOKEN_DATA1    = `TOK_DATA1
  } token_code_t;

  // ==========================================
  // carriers
  typedef struct packed {
    logic [3:0] code;
    logic [3:0] endpoint;
  } token_sel_t;

  typedef struct packed {
    logic        done;
    logic        iso;
    logic        ackSeen;
    logic        isoOk;
    logic        errorSeen;
    logic        timeout;
    logic        nakSeen;
    logic        stallSeen;
    logic        seqData1;
    logic        dataRx;
    logic [15:0] rxLength;
  } txn_result_t;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic stall;
    logic nak;
    logic lenExc;
    logic seq;
    logic timeout;
    logic error;
    logic ack;
  } ep_status_t;

  typedef struct packed {
    token_sel_t token;
    logic [6:0] targetAddr;
    logic       tokenLoad;
    logic       tokenLegal;
    logic       preamble;
    logic       handshake;
  } port_cmd_t;

endpackage

// ---- rtl/txn_result_capture.sv ----
// per-port capture of transaction status and count difference
`include "usb_host_txn_cfg.svh"

module txn_result_capture (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // engine result
  input  wire usb_host_txn_pkg::txn_result_t result,
  input  wire logic [9:0]                    hostCount,
  // captured state
  output usb_host_txn_pkg::ep_status_t       status,
  output logic [15:0]                        countDiff
);

  // ==========================================
  // difference arithmetic
  function automatic logic [15:0] count_difference(input logic [9:0] cnt, input logic [15:0] rxLen);
    logic [15:0] diff;
    diff = {6'h00, cnt} - rxLen;
    if (rxLen > {6'h00, cnt}) begin
      diff[`DIFF_OVF_MSB:`DIFF_OVF_LSB] = `DIFF_OVF_FILL;
    end
    return diff;
  endfunction

  // ==========================================
  // capture on completion
  usb_host_txn_pkg::ep_status_t statusFf;
  usb_host_txn_pkg::ep_status_t nxtStatusFf;
  logic [15:0]                  diffFf;
  logic [15:0]                  nxtDiffFf;
  logic                         over;
  logic                         under;

  always_comb begin
    nxtStatusFf = statusFf;
    nxtDiffFf   = diffFf;
    over        = result.dataRx && (result.rxLength > {6'h00, hostCount});
    under       = result.dataRx && (result.rxLength < {6'h00, hostCount});
    if (result.done) begin
      // both updated in the same cycle, held until the next completion
      nxtStatusFf.ack       = result.iso ? result.isoOk : result.ackSeen;
      nxtStatusFf.error     = result.errorSeen;
      nxtStatusFf.timeout   = result.timeout;
      nxtStatusFf.nak       = result.nakSeen;
      nxtStatusFf.stall     = result.stallSeen;
      nxtStatusFf.seq       = result.errorSeen ? 1'b0 : result.seqData1;
      nxtStatusFf.lenExc    = over || under;
      nxtStatusFf.overflow  = over;
      nxtStatusFf.underflow = under;
      nxtDiffFf             = result.dataRx ? count_difference(hostCount, result.rxLength)
                                            : `COUNT_DIFF_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusFf <= '0;
      diffFf   <= `COUNT_DIFF_RST;
    end else begin
      statusFf <= nxtStatusFf;
      diffFf   <= nxtDiffFf;
    end
  end

  assign status    = statusFf;
  assign countDiff = diffFf;

endmodule

// ---- verification/usb_engine_model.sv ----
// engine completion reporter standing beyond the transaction registers
module usb_engine_model (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // bench requests
  input  wire logic                          fire [2],
  input  wire usb_host_txn_pkg::txn_result_t req  [2],
  // toward the block
  output usb_host_txn_pkg::txn_result_t      res  [2]
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle done; idle payload inverted each cycle so nothing stale looks valid
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (!rst_n)
        res[p] <= '0;
      else
        res[p] <= fire[p] ? req[p] : {1'b0, ~res[p][24:0]};
    end
  end
endmodule

// ---- verification/usb_host_transaction_regs_assertions.sv ----
// port assertions for the host transaction registers
`include "usb_host_txn_cfg.svh"

module usb_host_transaction_regs_checker #(
  parameter int NUM_PORTS = 2
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // register bus
  input  wire logic [15:0]                   regAddr,
  input  wire logic                          regWrEn,
  input  wire logic [15:0]                   regWrData,
  input  wire logic                          regRdEn,
  input  wire logic [15:0]                   regRdData,
  input  wire logic                          regRdValid,
  // engine side
  input  wire usb_host_txn_pkg::txn_result_t portResult [NUM_PORTS],
  input  wire logic [9:0]                    hostCount  [NUM_PORTS],
  input  wire usb_host_txn_pkg::port_cmd_t   portCmd    [NUM_PORTS]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================
  // expected port 0 result
  wire usb_host_txn_pkg::txn_result_t r = portResult[0];
  wire logic [15:0] hc      = {6'h00, hostCount[0]};
  wire logic [15:0] rawDiff = hc - r.rxLength;
  wire logic        over    = r.dataRx && r.rxLength > hc;
  wire logic        under   = r.dataRx && r.rxLength < hc;
  wire logic        wrTok   = regWrEn && regAddr == `HOST1_TOKEN_SELECT_OFS;
  wire logic        wrAdr   = regWrEn && regAddr == `HOST1_COUNT_DIFF_OFS;
  wire logic        rdSt    = regRdEn && regAddr == `HOST1_TOKEN_SELECT_OFS && !r.done;
  wire logic        rdDf    = regRdEn && regAddr == `HOST1_COUNT_DIFF_OFS && !r.done;
  logic             ack_ff;
  logic             len_ff;
  logic             ovf_ff;
  logic [15:0]      diff_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {ack_ff, len_ff, ovf_ff, diff_ff} <= '0;
    end else if (r.done) begin
      ack_ff  <= r.iso ? r.isoOk : r.ackSeen;
      len_ff  <= over | under;
      ovf_ff  <= over;
      diff_ff <= !r.dataRx ? 16'h0000 : over ? {`DIFF_OVF_FILL, rawDiff[9:0]} : rawDiff;
    end
  end

  // ==========================================
  // assertions
  property p_rd_pulse; regRdEn |=> regRdValid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
  property p_rd_idle; !regRdValid |-> regRdData == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without valid");
  property p_ack; rdSt |=> regRdData[0] == ack_ff && regRdData[5] == len_ff; endproperty
  a_ack: assert property (p_ack) else $error("status flags wrong");
  property p_diff; rdDf |=> regRdData == diff_ff; endproperty
  a_diff: assert property (p_diff) else $error("count difference wrong");
  property p_ovf; rdDf && ovf_ff |=> regRdData[15:10] == 6'h3F; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow fill missing");
  property p_tok;
    1 |=> portCmd[0].tokenLoad == $past(wrTok)
      && portCmd[0].token == ($past(wrTok) ? $past(regWrData[7:0]) : $past(portCmd[0].token));
  endproperty
  a_tok: assert property (p_tok) else $error("token register wrong");
  property p_addr;
    1 |=> portCmd[0].targetAddr == ($past(wrAdr) ? $past(regWrData[6:0]) : $past(portCmd[0].targetAddr));
  endproperty
  a_addr: assert property (p_addr) else $error("target address wrong");
  property p_hs;
    portCmd[0].handshake == (portCmd[0].token.code inside {4'hA, 4'hE})
      && portCmd[0].preamble == (portCmd[0].token.code == 4'hC);
  endproperty
  a_hs: assert property (p_hs) else $error("handshake decode wrong");
  c_ovf: cover property (rdDf && ovf_ff);
  c_iso: cover property (r.done && r.iso);
  c_hs: cover property (portCmd[0].handshake);
endmodule

bind usb_host_transaction_regs usb_host_transaction_regs_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
  .portResult(portResult), .hostCount(hostCount), .portCmd(portCmd));

// ---- verification/tb_usb_host_transaction_regs.sv ----
// self-checking bench for the host transaction registers
`include "usb_host_txn_cfg.svh"

module tb_usb_host_transaction_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef usb_host_txn_pkg::txn_result_t res_t;
  logic        clk = 1'b0;
  logic        rst_n;
  logic [15:0] regAddr = '0;
  logic [15:0] regWrData = '0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic        regRdValid;
  logic        fire [2] = '{1'b0, 1'b0};
  res_t        req [2] = '{'0, '0};
  res_t        portResult [2];
  logic [9:0]  hostCount [2] = '{10'h000, 10'h000};
  usb_host_txn_pkg::port_cmd_t portCmd [2];
  logic [15:0] stOf [2] = '{`HOST1_TOKEN_SELECT_OFS, `HOST2_TOKEN_SELECT_OFS};
  logic [15:0] dfOf [2] = '{`HOST1_COUNT_DIFF_OFS, `HOST2_COUNT_DIFF_OFS};
  logic [3:0]  codes [10] = '{4'hD, 4'h9, 4'h1, 4'h5, 4'hC, 4'hA, 4'hE, 4'h3, 4'hB, 4'h2};
  logic [15:0] corner [3] = '{16'h000C, 16'h0008, 16'h0007};
  logic [15:0] d;
  res_t        r;
  int          p;
  int          n_fail = 0;
  int          tests_run = 0;

  initial forever #4 clk = ~clk;

  usb_host_transaction_regs #(.NUM_PORTS(2)) dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .portResult(portResult), .hostCount(hostCount), .portCmd(portCmd));
  usb_engine_model engine (.clk(clk), .rst_n(rst_n), .fire(fire), .req(req), .res(portResult));

  // ==========================================
  // bus and compare tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk) #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(posedge clk) #1;
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk) #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk) #1;
    regRdEn = 1'b0;
    check({15'h0000, regRdValid}, 16'h0001);
    check(regRdData, e);
  endtask

  task automatic finish(input int q, input res_t x);
    @(posedge clk) #1;
    req[q] = x;
    fire[q] = 1'b1;
    @(posedge clk) #1;
    fire[q] = 1'b0;
  endtask

  task automatic reset_check();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 2; i++) begin
      rd(stOf[i], 16'h0000);
      rd(dfOf[i], 16'h0000);
      check({1'b0, portCmd[i].targetAddr, portCmd[i].token}, 16'h0000);
    end
    rd(16'hC08A, 16'h0000);
  endtask

  // ==========================================
  // expectations
  function automatic logic [15:0] exp_st(input res_t x, input logic [9:0] c);
    logic ov;
    logic un;
    ov = x.dataRx && x.rxLength > {6'h00, c};
    un = x.dataRx && x.rxLength < {6'h00, c};
    return {4'h0, ov, un, 2'b00, x.stallSeen, x.nakSeen, ov | un, 1'b0,
            x.errorSeen ? 1'b0 : x.seqData1, x.timeout, x.errorSeen, x.iso ? x.isoOk : x.ackSeen};
  endfunction

  function automatic logic [15:0] exp_df(input res_t x, input logic [9:0] c);
    logic [15:0] t;
    t = {6'h00, c} - x.rxLength;
    if (!x.dataRx)
      return 16'h0000;
    return x.rxLength > {6'h00, c} ? {6'h3F, t[9:0]} : t;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t run did not finish", $time);
    wrap_up();
  end

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(44));
    reset_check();
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      p = $urandom_range(0, 1);
      d = {8'h00, codes[i], 4'($urandom)};
      wr(stOf[p], d);
      check({8'h00, portCmd[p].token}, d);
      check({12'h000, portCmd[p].tokenLoad, portCmd[p].tokenLegal, portCmd[p].handshake, portCmd[p].preamble},
            {12'h000, 1'b1, i < 9, codes[i] inside {4'hA, 4'hE}, codes[i] == 4'hC});
    end
    $display("token codes done");
    for (int i = 0; i < 40; i++) begin
      p = i % 2;
      r = res_t'(26'($urandom));
      r.done = 1'b1;
      hostCount[p] = i < 3 ? 10'h008 : 10'($urandom);
      r.rxLength = 16'($urandom_range(0, 1100));
      if (i < 3) begin
        r.dataRx = 1'b1;
        r.rxLength = corner[i];
      end
      finish(p, r);
      rd(stOf[p], exp_st(r, hostCount[p]));
      d = 16'($urandom_range(0, 127));
      wr(dfOf[p], d);
      check({9'h000, portCmd[p].targetAddr}, d);
      rd(dfOf[p], exp_df(r, hostCount[p]));
    end
    $display("transaction results done");
    @(posedge clk) #1;
    reset_check();
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
